// ==== logic/ext_pkg.sv ====
// Purpose: shared constants for the bus timing of the i2c extender
// Assumes: 125 MHz system clock
// Notes:   per-speed tables are indexed by the decoded speed code
`default_nettype none
package ext_pkg;
	localparam int CLK_MHZ = 125;
	localparam int CW = 25;
	localparam int TW = 11;

	function automatic logic [TW-1:0] ns2cyc(input int ns);
		return TW'((ns * CLK_MHZ + 999) / 1000);
	endfunction

	// power control and bus monitor times
	localparam int ON_LOW_NS = 1000;
	localparam int ON_LOW_CYC = (ON_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int T_READY_US = 65;
	localparam int READY_CYC = T_READY_US * CLK_MHZ;
	localparam int T_RRST_MS = 180;
	localparam int RRST_CYC = T_RRST_MS * 1000 * CLK_MHZ;
	localparam int T_TIMEOUT_US = 31500;
	localparam int TIMEOUT_CYC = T_TIMEOUT_US * CLK_MHZ;
	localparam int T_IDLE_US = 70;
	localparam int IDLE_CYC = T_IDLE_US * CLK_MHZ;

	// speed codes and three-level pin codes
	localparam logic [1:0] SPD_FMP = 2'h0;
	localparam logic [1:0] SPD_FM = 2'h1;
	localparam logic [1:0] SPD_SM = 2'h2;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h3;

	// remote master timing, one entry per speed code
	localparam logic [TW-1:0] HIGH_CYC [3] = '{ns2cyc(400), ns2cyc(1000), ns2cyc(3800)};
	localparam logic [TW-1:0] LOW_CYC [3] = '{ns2cyc(1000 - 400), ns2cyc(2500 - 1000),
		ns2cyc(10000 - 3800)};
	localparam logic [TW-1:0] PER_CYC [3] = '{ns2cyc(1000), ns2cyc(2500), ns2cyc(10000)};
	localparam logic [TW-1:0] BUF_CYC [3] = '{ns2cyc(600), ns2cyc(1500), ns2cyc(5000)};
	localparam logic [TW-1:0] HDSTA_CYC [3] = '{ns2cyc(300), ns2cyc(800), ns2cyc(4200)};
	localparam logic [TW-1:0] SUSTA_CYC [3] = '{ns2cyc(300), ns2cyc(800), ns2cyc(4800)};
	localparam logic [TW-1:0] SUSTO_CYC [3] = '{ns2cyc(300), ns2cyc(800), ns2cyc(4200)};

	// synchronised pin vector layout
	localparam int P_ON = 0;
	localparam int P_REMOTE = 1;
	localparam int P_SCL = 2;
	localparam int P_SDA = 3;
	localparam int P_LCLK = 4;
	localparam int P_RATE = 5;
	localparam int P_WORD = 9;
	localparam int WORD_W = 10;
	localparam int PIN_W = P_WORD + WORD_W;
	localparam int W_STOP = 8;
	localparam int W_START = 9;
	localparam int FIFO_DEPTH = 4;
endpackage
`default_nettype wire

// ==== logic/word_fifo_if.sv ====
// Purpose: valid/ready carrier between the link capture and the word store
// Assumes: one clock for both sides
// Notes:   store is the buffer side, user the side that fills and drains
`timescale 1ns/1ps
`default_nettype none
interface word_fifo_if #(parameter int W = 10);
	logic         wr_valid;
	logic         wr_ready;
	logic [W-1:0] wr_data;
	logic         rd_valid;
	logic         rd_ready;
	logic [W-1:0] rd_data;
	modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
	modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// ==== logic/word_fifo.sv ====
// Purpose: small flip-flop fifo for link words
// Assumes: depth is a power of two
// Notes:   full and empty from pointers with one extra wrap bit
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 4
) (
	input  wire logic       clk_sys_in,
	input  wire logic       nrst_in,
	word_fifo_if.store      f
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [W-1:0] mem_nxt [DEPTH];
	logic [AW:0]  wp_r, wp_nxt, rp_r, rp_nxt;
	logic         full, empty;

	assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign empty = (wp_r == rp_r);
	assign f.wr_ready = !full;
	assign f.rd_valid = !empty;
	assign f.rd_data = mem_r[rp_r[AW-1:0]];

	always_comb begin
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		if (f.wr_valid && !full) begin
			mem_nxt[wp_r[AW-1:0]] = f.wr_data;
			wp_nxt = wp_r + 1'b1;
		end
		if (f.rd_ready && !empty) begin
			rp_nxt = rp_r + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wp_r <= '0;
			rp_r <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			mem_r <= mem_nxt;
		end
	end
endmodule
`default_nettype wire

// ==== logic/i2c_extender_bus_timing.sv ====
// Purpose: power control, bus monitor and remote-mode bus master of the extender
// Assumes: all pins asynchronous to clk_sys_in; link words arrive with a slow link clock
// Notes:   remote master writes only; the acknowledge bit is clocked but not checked
//
// Notes on behaviour
// R1: the controlling party holds the power control input low at least 1 us for a valid reset.
// R2: in local mode with the bus idle, ready goes low 65 us after the power control input rises.
// R3: in local mode, power control low for 180 ms is passed on as a remote reset.
// R4: the local side accepts host scl from 10 kHz to 2000 kHz and the host stays in that range.
// R5: the host leaves at least 0.5, 1.3 or 4.7 us bus free between stop and start.
// R6: the host gives a stop setup of at least 0.26, 0.6 or 4 us.
// R7: scl held low for 28 to 35 ms is reported as a timeout.
// R8: the bus is declared idle only after scl has been high for 70 us.
// R9: the remote master's scl period is no less than 1, 2.5 or 10 us.
// R10: the remote master waits at least 0.5, 1.3 or 4.7 us between stop and next start.
// R11: the remote master holds scl high after a start for at least 0.26, 0.6 or 4 us.
// R12: the remote master gives a repeated start setup of at least 0.26, 0.6 or 4.7 us.
// R13: the two three-level speed selects decode to fm+, fm or sm and pick all remote master timing.
// R14: side select low runs local slave behaviour, high runs remote master behaviour.
`timescale 1ns/1ps
`default_nettype none
module i2c_extender_bus_timing #(
	parameter int READY_CYC   = ext_pkg::READY_CYC,
	parameter int RRST_CYC    = ext_pkg::RRST_CYC,
	parameter int TIMEOUT_CYC = ext_pkg::TIMEOUT_CYC,
	parameter int IDLE_CYC    = ext_pkg::IDLE_CYC
) (
	input  wire logic                        clk_sys_in,
	input  wire logic                        nrst_in,
	input  wire logic                        power_on_in,
	input  wire logic                        remote_mode_in,
	input  wire logic [1:0]                  rate_select_first_in,
	input  wire logic [1:0]                  rate_select_second_in,
	input  wire logic                        scl_in,
	output logic                             scl_out,
	output logic                             scl_oe_n_out,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe_n_out,
	input  wire logic                        link_clk_in,
	input  wire logic [ext_pkg::WORD_W-1:0]  link_word_in,
	output logic                             link_ready_out,
	output logic                             ready_n_out,
	output logic                             remote_reset_out,
	output logic                             scl_timeout_out,
	output logic                             bus_idle_out
);
	localparam int CW = ext_pkg::CW;
	localparam int TW = ext_pkg::TW;
	localparam logic [CW-1:0] ON_LOW_L = CW'(ext_pkg::ON_LOW_CYC);
	localparam logic [CW-1:0] READY_L = CW'(READY_CYC);
	localparam logic [CW-1:0] RRST_L = CW'(RRST_CYC);
	localparam logic [CW-1:0] TIMEOUT_L = CW'(TIMEOUT_CYC);
	localparam logic [CW-1:0] IDLE_L = CW'(IDLE_CYC);

	typedef enum logic [9:0] {
		M_IDLE  = 10'h001, M_START = 10'h002, M_LOW  = 10'h004, M_HIGH  = 10'h008,
		M_HOLD  = 10'h010, M_PRS   = 10'h020, M_SUSTA = 10'h040, M_PSTOP = 10'h080,
		M_SUSTO = 10'h100, M_BUF   = 10'h200
	} mst_e;

	function automatic logic [1:0] speed_of(input logic [1:0] a, input logic [1:0] b);
		if (a == ext_pkg::LVL_HIGH && b == ext_pkg::LVL_HIGH) begin
			return ext_pkg::SPD_FMP;
		end else if (a == ext_pkg::LVL_MID || b == ext_pkg::LVL_MID) begin
			return ext_pkg::SPD_FM;
		end
		return ext_pkg::SPD_SM;
	endfunction

	// pin synchronisers: three stages, a change counts once stages two and three agree
	logic [ext_pkg::PIN_W-1:0] raw, s1_r, s2_r, s3_r, pin_r, pin_nxt;
	assign raw = {link_word_in, rate_select_second_in, rate_select_first_in, link_clk_in,
		sda_in, scl_in, remote_mode_in, power_on_in};
	generate
		for (genvar i = 0; i < ext_pkg::PIN_W; i++) begin : g_sync
			always_comb begin
				pin_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pin_r[i]; // [R4]
			end
		end
	endgenerate

	logic on_f, remote_f, scl_f, lclk_f;
	assign on_f = pin_r[ext_pkg::P_ON];
	assign remote_f = pin_r[ext_pkg::P_REMOTE];
	assign scl_f = pin_r[ext_pkg::P_SCL];
	assign lclk_f = pin_r[ext_pkg::P_LCLK];

	// power control, ready, remote reset, bus monitor
	logic [CW-1:0] on_low_r, on_low_nxt, on_hi_r, on_hi_nxt, scl_lo_r, scl_lo_nxt;
	logic [CW-1:0] scl_hi_r, scl_hi_nxt;
	logic          ready_n_r, ready_n_nxt, rrst_r, rrst_nxt, to_r, to_nxt, idle_r, idle_nxt;
	logic [1:0]    spd_r, spd_nxt;
	logic          lclk_d_r, link_rdy_r;

	always_comb begin
		on_low_nxt = on_f ? '0 : (on_low_r == RRST_L ? on_low_r : on_low_r + 1'b1);
		on_hi_nxt = on_hi_r;
		ready_n_nxt = ready_n_r;
		if (!on_f) begin
			on_hi_nxt = '0;
			if (on_low_r >= ON_LOW_L - 1'b1) begin
				ready_n_nxt = 1'b1; // [R1]
			end
		end else if ((remote_f || idle_r) && on_hi_r != READY_L) begin
			on_hi_nxt = on_hi_r + 1'b1;
			if (on_hi_r == READY_L - 1'b1) begin
				ready_n_nxt = 1'b0; // [R2]
			end
		end
		rrst_nxt = !remote_f && !on_f && on_low_r == RRST_L - 1'b1; // [R3]
		scl_lo_nxt = scl_f ? '0 : (scl_lo_r == TIMEOUT_L ? scl_lo_r : scl_lo_r + 1'b1);
		to_nxt = scl_lo_nxt == TIMEOUT_L; // [R7]
		scl_hi_nxt = !scl_f ? '0 : (scl_hi_r == IDLE_L ? scl_hi_r : scl_hi_r + 1'b1);
		idle_nxt = scl_hi_nxt == IDLE_L; // [R8]
		spd_nxt = speed_of(pin_r[ext_pkg::P_RATE +: 2], pin_r[ext_pkg::P_RATE+2 +: 2]); // [R13]
	end

	// link capture into the word fifo on each rising link clock edge
	word_fifo_if #(.W(ext_pkg::WORD_W)) fq ();
	word_fifo #(.W(ext_pkg::WORD_W), .DEPTH(ext_pkg::FIFO_DEPTH)) u_fifo (
		.clk_sys_in (clk_sys_in),
		.nrst_in    (nrst_in),
		.f          (fq)
	);
	// a word offered while the fifo is full is dropped; the link side must watch ready
	assign fq.wr_valid = lclk_f && !lclk_d_r;
	assign fq.wr_data = pin_r[ext_pkg::P_WORD +: ext_pkg::WORD_W];

	// remote master
	mst_e          st_r, st_nxt;
	logic [TW-1:0] tmr_r, tmr_nxt;
	logic [3:0]    bit_r, bit_nxt;
	logic [7:0]    sh_r, sh_nxt;
	logic          stop_r, stop_nxt, scl_lv_r, scl_lv_nxt, sda_lv_r, sda_lv_nxt, take;
	logic [ext_pkg::WORD_W-1:0] w;
	assign w = fq.rd_data;
	assign fq.rd_ready = take;

	always_comb begin
		st_nxt = st_r;
		tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		stop_nxt = stop_r;
		scl_lv_nxt = scl_lv_r;
		sda_lv_nxt = sda_lv_r;
		take = 1'b0;
		unique case (st_r)
			M_IDLE: if (remote_f && on_f && fq.rd_valid) begin // [R14]
				take = 1'b1;
				sh_nxt = w[7:0];
				stop_nxt = w[ext_pkg::W_STOP];
				sda_lv_nxt = 1'b0;
				tmr_nxt = ext_pkg::HDSTA_CYC[spd_r] - 1'b1;
				st_nxt = M_START;
			end
			M_START: if (tmr_r == '0) begin // [R11]
				scl_lv_nxt = 1'b0;
				sda_lv_nxt = sh_r[7];
				bit_nxt = '0;
				tmr_nxt = ext_pkg::LOW_CYC[spd_r] - 1'b1;
				st_nxt = M_LOW;
			end
			M_LOW: if (tmr_r == '0) begin
				scl_lv_nxt = 1'b1;
				tmr_nxt = ext_pkg::HIGH_CYC[spd_r] - 1'b1; // [R9]
				st_nxt = M_HIGH;
			end
			M_HIGH: if (tmr_r == '0) begin
				scl_lv_nxt = 1'b0;
				tmr_nxt = ext_pkg::LOW_CYC[spd_r] - 1'b1; // [R9]
				if (bit_r == 4'h8) begin
					sda_lv_nxt = !stop_r;
					st_nxt = stop_r ? M_PSTOP : M_HOLD;
				end else begin
					bit_nxt = bit_r + 1'b1;
					sh_nxt = {sh_r[6:0], 1'b1};
					sda_lv_nxt = sh_r[6];
					st_nxt = M_LOW;
				end
			end
			// scl held low by us while the next word is awaited
			M_HOLD: if (tmr_r == '0 && fq.rd_valid) begin
				take = 1'b1;
				sh_nxt = w[7:0];
				stop_nxt = w[ext_pkg::W_STOP];
				bit_nxt = '0;
				sda_lv_nxt = w[ext_pkg::W_START] ? 1'b1 : w[7];
				tmr_nxt = ext_pkg::LOW_CYC[spd_r] - 1'b1;
				st_nxt = w[ext_pkg::W_START] ? M_PRS : M_LOW;
			end
			M_PRS: if (tmr_r == '0) begin
				scl_lv_nxt = 1'b1;
				tmr_nxt = ext_pkg::SUSTA_CYC[spd_r] - 1'b1; // [R12]
				st_nxt = M_SUSTA;
			end
			M_SUSTA: if (tmr_r == '0) begin
				sda_lv_nxt = 1'b0;
				tmr_nxt = ext_pkg::HDSTA_CYC[spd_r] - 1'b1; // [R11]
				st_nxt = M_START;
			end
			M_PSTOP: if (tmr_r == '0) begin
				scl_lv_nxt = 1'b1;
				tmr_nxt = ext_pkg::SUSTO_CYC[spd_r] - 1'b1;
				st_nxt = M_SUSTO;
			end
			M_SUSTO: if (tmr_r == '0) begin
				sda_lv_nxt = 1'b1;
				tmr_nxt = ext_pkg::BUF_CYC[spd_r] - 1'b1; // [R10]
				st_nxt = M_BUF;
			end
			M_BUF: if (tmr_r == '0) begin
				st_nxt = M_IDLE;
			end
		endcase
		// leaving remote mode or power-down abandons the transfer and frees the bus
		if (!remote_f || !on_f) begin // [R14]
			st_nxt = M_IDLE;
			scl_lv_nxt = 1'b1;
			sda_lv_nxt = 1'b1;
			take = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			pin_r <= '0;
			on_low_r <= '0;
			on_hi_r <= '0;
			scl_lo_r <= '0;
			scl_hi_r <= '0;
			ready_n_r <= 1'b1;
			rrst_r <= 1'b0;
			to_r <= 1'b0;
			idle_r <= 1'b0;
			spd_r <= ext_pkg::SPD_SM;
			lclk_d_r <= 1'b0;
			link_rdy_r <= 1'b0;
			st_r <= M_IDLE;
			tmr_r <= '0;
			bit_r <= '0;
			sh_r <= '0;
			stop_r <= 1'b0;
			scl_lv_r <= 1'b1;
			sda_lv_r <= 1'b1;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_r <= pin_nxt;
			on_low_r <= on_low_nxt;
			on_hi_r <= on_hi_nxt;
			scl_lo_r <= scl_lo_nxt;
			scl_hi_r <= scl_hi_nxt;
			ready_n_r <= ready_n_nxt;
			rrst_r <= rrst_nxt;
			to_r <= to_nxt;
			idle_r <= idle_nxt;
			spd_r <= spd_nxt;
			lclk_d_r <= lclk_f;
			link_rdy_r <= fq.wr_ready;
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			stop_r <= stop_nxt;
			scl_lv_r <= scl_lv_nxt;
			sda_lv_r <= sda_lv_nxt;
		end
	end

	// open drain: the level flop doubles as the active-low enable
	assign scl_out = scl_lv_r;
	assign scl_oe_n_out = scl_lv_r;
	assign sda_out = sda_lv_r;
	assign sda_oe_n_out = sda_lv_r;
	assign link_ready_out = link_rdy_r;
	assign ready_n_out = ready_n_r;
	assign remote_reset_out = rrst_r;
	assign scl_timeout_out = to_r;
	assign bus_idle_out = idle_r;

	// helper counters for the checks below
	logic [15:0] stand_r, rise_r;
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stand_r <= '0;
			rise_r <= '0;
		end else begin
			stand_r <= (scl_lv_nxt != scl_lv_r || sda_lv_nxt != sda_lv_r) ? '0 : stand_r + 1'b1;
			rise_r <= (scl_lv_nxt && !scl_lv_r) ? '0 : rise_r + 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	a_ready_delay: assert property ($fell(ready_n_r) |-> on_hi_r == READY_L && $past(on_f) && $past(remote_f || idle_r)) else $error("ready fell early"); // [R2]
	a_remote_reset: assert property ($rose(rrst_r) |-> on_low_r == RRST_L ##1 !rrst_r) else $error("remote reset wrong"); // [R3]
	a_scl_timeout: assert property (to_r |-> !$past(scl_f) && scl_lo_r == TIMEOUT_L) else $error("timeout without long low"); // [R7]
	a_bus_idle: assert property ($rose(idle_r) |-> $past(scl_f, 2) && scl_hi_r == IDLE_L) else $error("idle too soon"); // [R8]
	a_scl_period: assert property ($rose(scl_lv_r) && $past(st_r) == M_LOW |-> $past(rise_r) + 16'h1 >= 16'(ext_pkg::PER_CYC[spd_r])) else $error("scl period short"); // [R9]
	a_bus_free: assert property ($fell(sda_lv_r) && $past(st_r) == M_IDLE |-> $past(stand_r) + 16'h1 >= 16'(ext_pkg::BUF_CYC[spd_r])) else $error("bus free short"); // [R10]
	a_start_hold: assert property ($fell(scl_lv_r) && $past(st_r) == M_START |-> $past(stand_r) + 16'h1 >= 16'(ext_pkg::HDSTA_CYC[spd_r])) else $error("start hold short"); // [R11]
	a_rs_setup: assert property ($fell(sda_lv_r) && $past(st_r) == M_SUSTA |-> scl_lv_r && $past(stand_r) + 16'h1 >= 16'(ext_pkg::SUSTA_CYC[spd_r])) else $error("restart setup short"); // [R12]
	a_speed_decode: assert property ($stable(pin_r[8:5]) [*2] |-> spd_r == speed_of(pin_r[6:5], pin_r[8:7])) else $error("speed decode mismatch"); // [R13]
	a_local_quiet: assert property (!remote_f ##1 !remote_f |-> scl_oe_n_out && sda_oe_n_out) else $error("master drives in local mode"); // [R14]
endmodule
`default_nettype wire

// ==== verification/bus_peer.sv ====
// Purpose: remote i2c target and host model, with timing capture
// Assumes: both wires sampled on the system clock, pull-ups on both lines
// Notes:   acks the first byte after each start; hold input plays a host holding scl low
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
	input  wire logic clk_sys_in,
	input  wire logic scl_oe_n_in,
	input  wire logic sda_oe_n_in,
	input  wire logic hold_scl_in,
	input  wire logic clear_in,
	output logic      scl_out,
	output logic      sda_out,
	output logic [7:0] byte_out,
	output var int    nbytes_out,
	output var int    min_per_out,
	output var int    min_hd_out,
	output var int    min_su_out,
	output var int    min_buf_out
);
	logic       p_scl = 1'b1;
	logic       p_sda = 1'b1;
	logic       ack_r = 1'b0;
	logic       stopped = 1'b0;
	logic       started = 1'b0;
	logic [7:0] sh = 8'h00;
	int         c_scl = 0;
	int         c_sda = 0;
	int         last_hi = 0;
	int         bits = 0;

	function automatic int mn(input int a, input int b);
		return (a < b) ? a : b;
	endfunction

	// released lines rise through the pull-ups, never hold a stale value
	// host side only holds scl low, never a start or stop of its own
	assign scl_out = scl_oe_n_in & ~hold_scl_in;
	assign sda_out = sda_oe_n_in & ~ack_r;

	initial begin
		byte_out = 8'h00;
		nbytes_out = 0;
	end

	always @(posedge clk_sys_in) begin
		p_scl <= scl_out;
		p_sda <= sda_out;
		c_scl <= (scl_out != p_scl) ? 1 : c_scl + 1;
		c_sda <= (sda_out != p_sda) ? 1 : c_sda + 1;
		if (clear_in) begin
			min_per_out <= 99999;
			min_hd_out <= 99999;
			min_su_out <= 99999;
			min_buf_out <= 99999;
		end
		if (scl_out && p_scl && p_sda && !sda_out) begin
			min_su_out <= mn(min_su_out, c_scl);
			if (stopped)
				min_buf_out <= mn(min_buf_out, c_sda);
			stopped <= 1'b0;
			started <= 1'b1;
			bits <= 0;
		end
		if (scl_out && p_scl && !p_sda && sda_out)
			stopped <= 1'b1;
		if (scl_out && !p_scl) begin
			// first rise after a start is skipped: the high phase before it is the start hold
			if (bits > 0 && bits < 9)
				min_per_out <= mn(min_per_out, c_scl + last_hi);
			if (bits < 8)
				sh <= {sh[6:0], sda_out};
			bits <= bits + 1;
		end
		if (!scl_out && p_scl) begin
			last_hi <= c_scl;
			if (started)
				min_hd_out <= mn(min_hd_out, c_sda);
			started <= 1'b0;
			ack_r <= (bits == 8);
			if (bits == 9) begin
				nbytes_out <= nbytes_out + 1;
				byte_out <= sh;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/tb_i2c_extender_bus_timing.sv ====
// Purpose: self-checking bench for the extender bus timing block
// Assumes: shortened ready, reset, timeout and idle counts
// Notes:   link words are sent with an 80 ns link clock, idle between words
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_extender_bus_timing;
	typedef struct packed {
		logic [1:0]  r1;
		logic [1:0]  r2;
		logic [7:0]  data;
		logic [15:0] per;
		logic [15:0] hd;
		logic [15:0] su;
		logic [15:0] bf;
	} row_s;
	logic       clk_sys_in = 1'b0;
	logic       nrst_in = 1'b0;
	logic       power_on = 1'b1;
	logic       remote = 1'b0;
	logic       link_clk = 1'b0;
	logic       hold = 1'b0;
	logic       clear = 1'b1;
	logic [1:0] rs1 = 2'h0;
	logic [1:0] rs2 = 2'h0;
	logic [9:0] word = 10'h000;
	logic       scl, sda, scl_o, scl_oe_n, sda_o, sda_oe_n;
	logic       link_ready, ready_n, rreset, tmo, idle;
	logic [7:0] rx;
	int         nbytes, mper, mhd, msu, mbuf;
	int         failures = 0;
	int         tests_run = 0;
	int         cycles = 0;
	int         resets = 0;
	int         base;
	row_s       rows[3] = '{
		'{2'h3, 2'h3, 8'ha5, 16'd125, 16'd33, 16'd33, 16'd63},
		'{2'h1, 2'h3, 8'h3c, 16'd313, 16'd75, 16'd75, 16'd163},
		'{2'h2, 2'h0, 8'hc3, 16'd1250, 16'd500, 16'd588, 16'd588}};

	i2c_extender_bus_timing #(.READY_CYC(40), .RRST_CYC(200), .TIMEOUT_CYC(300),
		.IDLE_CYC(50)) i_dut (
		.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .power_on_in(power_on),
		.remote_mode_in(remote), .rate_select_first_in(rs1), .rate_select_second_in(rs2),
		.scl_in(scl), .scl_out(scl_o), .scl_oe_n_out(scl_oe_n), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .link_clk_in(link_clk),
		.link_word_in(word), .link_ready_out(link_ready), .ready_n_out(ready_n),
		.remote_reset_out(rreset), .scl_timeout_out(tmo), .bus_idle_out(idle));

	bus_peer i_peer (
		.clk_sys_in(clk_sys_in), .scl_oe_n_in(scl_oe_n), .sda_oe_n_in(sda_oe_n),
		.hold_scl_in(hold), .clear_in(clear), .scl_out(scl), .sda_out(sda),
		.byte_out(rx), .nbytes_out(nbytes), .min_per_out(mper), .min_hd_out(mhd),
		.min_su_out(msu), .min_buf_out(mbuf));

	initial begin
		forever #4 clk_sys_in = ~clk_sys_in;
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic check_ge(input string name, input int lim, input int got);
		tests_run++;
		if (got < lim) begin
			failures++;
			$display("ERROR %s expected at least %0d seen %0d", name, lim, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask

	// 80 ns link clock, offset from the system clock; word set before its rise
	task automatic send(input logic [9:0] w);
		@(posedge clk_sys_in);
		word <= w;
		#36 link_clk = 1'b1;
		#40 link_clk = 1'b0;
	endtask

	task automatic wait_bytes(input int n);
		for (int i = 0; i < 50000 && nbytes < n; i++)
			@(posedge clk_sys_in);
	endtask

	task automatic close_out;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		if (rreset === 1'b1)
			resets++;
		cycles++;
		if (cycles == 80000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		cyc(2);
		check("reset outputs", 7'h70, {ready_n, scl_oe_n, sda_oe_n, rreset, tmo, idle, link_ready});
		cyc(2);
		nrst_in <= 1'b1;
		clear <= 1'b0;
		cyc(100);
		check("link ready", 1, link_ready);
		power_on <= 1'b0;
		cyc(140);
		check("ready_n after valid low", 1, ready_n);
		power_on <= 1'b1;
		cyc(20);
		check("ready_n early", 1, ready_n);
		cyc(40);
		check("ready_n late", 0, ready_n);
		power_on <= 1'b0;
		cyc(100);
		power_on <= 1'b1;
		cyc(10);
		check("ready_n short low", 0, ready_n);
		check("remote resets short", 0, resets);
		power_on <= 1'b0;
		cyc(220);
		power_on <= 1'b1;
		cyc(60);
		check("remote resets long", 1, resets);
		hold <= 1'b1;
		cyc(295);
		check("timeout early", 0, tmo);
		cyc(15);
		check("timeout late", 1, tmo);
		check("idle while low", 0, idle);
		hold <= 1'b0;
		cyc(45);
		check("idle early", 0, idle);
		cyc(15);
		check("idle late", 1, idle);
		check("timeout cleared", 0, tmo);
		remote <= 1'b1;
		foreach (rows[i]) begin
			rs1 <= rows[i].r1;
			rs2 <= rows[i].r2;
			clear <= 1'b1;
			cyc(20);
			clear <= 1'b0;
			base = nbytes;
			send({2'b00, rows[i].data});
			send({2'b11, ~rows[i].data});
			send({2'b01, rows[i].data ^ 8'h55});
			wait_bytes(base + 3);
			cyc(2000);
			check("byte", {24'h0, rows[i].data ^ 8'h55}, {24'h0, rx});
			check("byte count", base + 3, nbytes);
			check("scl period", rows[i].per, mper);
			check_ge("start hold", rows[i].hd, mhd);
			check_ge("restart setup", rows[i].su, msu);
			check_ge("bus free", rows[i].bf, mbuf);
		end
		rs1 <= 2'h3;
		rs2 <= 2'h3;
		remote <= 1'b0;
		cyc(20);
		base = nbytes;
		for (int k = 0; k < 5; k++)
			send({2'b01, 8'(8'h10 + k)});
		cyc(5);
		check("link ready full", 0, link_ready);
		check("local no drive", 1, scl_oe_n);
		check("local no bytes", base, nbytes);
		remote <= 1'b1;
		wait_bytes(base + 4);
		cyc(3000);
		check("drained count", base + 4, nbytes);
		check("last kept byte", 8'h13, rx);
		check("link ready drained", 1, link_ready);
		close_out();
	end
endmodule
`default_nettype wire
